// File: design/credit_play_regs.svh
// register offsets, field positions, reset values and timing counts
//
// Contract
// - coin deposit sets the play latch
// - switch picks one or two credits per coin
// - each credit pulse adds exactly one
// - play latch resets at power-up
// - last-ball miss clears latch if no credits
// - starts only in attract; remember which start
// - two-player start needs two credits
// - attract stays until a start clears it, end-of-game sets it
// - per-player bonus latch, once per sequence
// - bonus adds one credit, fires tone
// - credit counter saturates at fifteen
// - decode one-credit and two-credit flags
// - lit start press decrements credit counter
// - brick hit loads points, counts down
// - point pulses go to player up
// - three-digit BCD scores, cleared at start
// - empty-wall flag once, restores player bricks
// - ball out sets serve wait until serve
// - serve wait held off in attract
// - one advance two-player, two one-player
// - serves counter low bit is player up
// - end-of-game after three or five serves
// - one threshold setting disables bonus
// - play persists while credits remain
`ifndef CREDIT_PLAY_REGS_SVH
`define CREDIT_PLAY_REGS_SVH

`define CPS_ADDR_W 8
`define CPS_OFF_CONFIG 8'h00
`define CPS_OFF_STATUS 8'h04
`define CPS_OFF_SCORE 8'h08

`define CPS_CFG_TWO_CR_BIT 0
`define CPS_CFG_FIVE_BIT 1
`define CPS_CFG_THR_LSB 2
`define CPS_CFG_RESET 6'h00
`define CPS_SCORE_P2_LSB 16

`define CPS_CREDIT_MAX 4'hF
`define CPS_BALLS_SHORT 3'h3
`define CPS_BALLS_LONG 3'h5
`define CPS_BONUS_OFF 4'h0

`define CPS_CLK_NS 25
`define CPS_COIN_MIN_NS 20000
`define CPS_COIN_MIN_CYC \
    ((`CPS_COIN_MIN_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_TICK_NS 2000
`define CPS_TICK_CYC (`CPS_TICK_NS / `CPS_CLK_NS)
`define CPS_TONE_MS 500
`define CPS_TONE_CYC (`CPS_TONE_MS * 1000000 / `CPS_CLK_NS)

`endif

// File: design/credit_play_pkg.sv
// types shared by the credit and play sequencer
`default_nettype none
package credit_play_pkg;
    typedef struct packed {
        logic [3:0] bonusThresholdSwitch;
        logic servesPerGameSwitch;
        logic creditsPerCoinSwitch;
    } cfg_t;

    typedef struct packed {
        logic [3:0] serves;
        logic [1:0] wallFlags;
        logic [1:0] bonusLatched;
        logic creditOne;
        logic creditTwo;
        logic endOfGame;
        logic serveWait;
        logic attract;
        logic playLatch;
        logic [3:0] credits;
    } status_t;

    typedef enum logic [1:0] {
        SRV_IDLE,
        SRV_FIRST,
        SRV_SECOND
    } serve_state_t;
endpackage
`default_nettype wire

// File: design/bcd_score_counter.sv
// three-digit BCD score counter with synchronous clear
`default_nettype none
module bcd_score_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // control
    input wire logic clr,
    input wire logic inc,
    // score digits, hundreds in the top nibble
    output logic [11:0] digits
);
    logic [11:0] score_q;
    logic [11:0] score_d;
    logic carry;

    always_comb begin
        score_d = score_q;
        carry = inc;
        for (int i = 0; i < 3; i++) begin
            if (carry) begin
                if (score_q[4*i +: 4] == 4'h9) begin
                    score_d[4*i +: 4] = 4'h0;
                end else begin
                    score_d[4*i +: 4] = score_q[4*i +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
    end

    // clear wins: a point landing on the start cycle belongs to no game
    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            score_q <= 12'h000;
        end else begin
            score_q <= score_d;
        end
    end

    assign digits = score_q;
endmodule
`default_nettype wire

// File: design/credit_play_sequencer.sv
// coin, credit, start, scoring and serve sequencing for the game
`include "credit_play_regs.svh"
`default_nettype none
module credit_play_sequencer #(
    parameter int unsigned ToneCycles = `CPS_TONE_CYC,
    parameter int unsigned CoinMinCycles = `CPS_COIN_MIN_CYC,
    parameter int unsigned TickCycles = `CPS_TICK_CYC,
    parameter int unsigned BrickValueWidth = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // apb slave
    input wire logic [`CPS_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // coin and buttons
    input wire logic slotASwitch,
    input wire logic slotBSwitch,
    input wire logic startOneBtn,
    input wire logic startTwoBtn,
    input wire logic serveBtnN,
    // playfield events
    input wire logic brickHit,
    input wire logic [BrickValueWidth-1:0] brickValue,
    input wire logic paddleHit,
    input wire logic backWallHit,
    input wire logic wallEmpty,
    input wire logic ballOut,
    // game state out
    output logic playLatch,
    output logic attract,
    output logic startLamp1,
    output logic startLamp2,
    output logic serveLamp,
    output logic bonusTone,
    output logic pointPulse,
    output logic p1WallRestore,
    output logic p2WallRestore,
    output logic playerTwoUp,
    output logic endOfGameLevel,
    output logic [2:0] ballNumber
);
    credit_play_pkg::cfg_t cfg_q;
    credit_play_pkg::status_t status;
    credit_play_pkg::serve_state_t serveState_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic playLatch_q;
    logic attract_q;
    logic [3:0] credit_q;
    logic [3:0] credit_d;
    logic creditOne_q;
    logic creditTwo_q;
    logic [2:0] creditPend_q;
    logic creditAdd_q;
    logic [1:0] coinOk_q;
    logic [1:0] slotIn;
    logic [1:0] startPrev_q;
    logic twoPlayer_q;
    logic singleStartDebit;
    logic doubleStartDebit;
    logic seqStart;
    logic endGame;
    logic serveWait_q;
    logic serveWaitPrev_q;
    logic serveAdvancePulse_q;
    logic [3:0] servesCnt_q;
    logic endOfGame_q;
    logic [BrickValueWidth-1:0] pointsCnt_q;
    logic [15:0] tickCnt_q;
    logic scoringClock;
    logic pointPulse_q;
    logic [1:0] bonusLatch_q;
    logic [1:0] bonusPulse_q;
    logic [31:0] toneCnt_q;
    logic bonusTone_q;
    logic [1:0] wallFlag_q;
    logic [1:0] wallRestore_q;
    logic [23:0] scores;
    logic apbSetup;
    logic apbWrite;
    logic [2:0] ballLimit;

    // apb slave, zero wait states
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && pready_q;

    always_comb begin
        status = '0;
        status.credits = credit_q;
        status.playLatch = playLatch_q;
        status.attract = attract_q;
        status.serveWait = serveWait_q;
        status.endOfGame = endOfGame_q;
        status.creditTwo = creditTwo_q;
        status.creditOne = creditOne_q;
        status.bonusLatched = bonusLatch_q;
        status.wallFlags = wallFlag_q;
        status.serves = servesCnt_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apbSetup;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (apbSetup) begin
                unique case (paddr)
                    `CPS_OFF_CONFIG: prdata_q <= {26'h0, cfg_q};
                    `CPS_OFF_STATUS: prdata_q <= {14'h0, status};
                    `CPS_OFF_SCORE: prdata_q <= {4'h0, scores[23:12],
                                                 4'h0, scores[11:0]};
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_q <= `CPS_CFG_RESET;
        end else if (apbWrite && paddr == `CPS_OFF_CONFIG) begin
            cfg_q <= pwdata[5:0];
        end
    end

    // coin recognition
    assign slotIn = {slotBSwitch, slotASwitch};

    // a contact bounce shorter than the minimum width never counts
    for (genvar gs = 0; gs < 2; gs++) begin : g_slot
        logic [15:0] widthCnt_q;
        always_ff @(posedge ref_clk) begin
            if (srst || !slotIn[gs]) begin
                widthCnt_q <= 16'h0000;
                coinOk_q[gs] <= 1'b0;
            end else begin
                if (widthCnt_q != 16'hFFFF) begin
                    widthCnt_q <= widthCnt_q + 16'h0001;
                end
                coinOk_q[gs] <= widthCnt_q == 16'(CoinMinCycles - 1);
            end
        end
    end

    // coins become a train of single credit pulses, one per cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            creditPend_q <= 3'h0;
            creditAdd_q <= 1'b0;
        end else begin
            creditAdd_q <= creditPend_q != 3'h0;
            creditPend_q <= creditPend_q
                - {2'h0, creditPend_q != 3'h0}
                + ({2'h0, coinOk_q[0]} + {2'h0, coinOk_q[1]})
                  * (cfg_q.creditsPerCoinSwitch ? 3'h2 : 3'h1);
        end
    end

    // start recognition
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            startPrev_q <= 2'h0;
        end else begin
            startPrev_q <= {startTwoBtn, startOneBtn};
        end
    end

    // single start takes priority when both buttons land together
    assign singleStartDebit = startOneBtn && !startPrev_q[0] && attract_q
        && playLatch_q && credit_q != 4'h0;
    assign doubleStartDebit = startTwoBtn && !startPrev_q[1] && attract_q
        && playLatch_q && credit_q >= 4'h2 && !singleStartDebit;
    assign seqStart = singleStartDebit || doubleStartDebit;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            twoPlayer_q <= 1'b0;
        end else if (seqStart) begin
            twoPlayer_q <= doubleStartDebit;
        end
    end

    // credit accumulator
    always_comb begin
        logic [5:0] grown;
        grown = {2'h0, credit_q} + {5'h00, creditAdd_q}
            + {5'h00, bonusPulse_q[0]} + {5'h00, bonusPulse_q[1]};
        if (grown > {2'h0, `CPS_CREDIT_MAX}) begin
            grown = {2'h0, `CPS_CREDIT_MAX};
        end
        if (doubleStartDebit) begin
            grown = grown - 6'h02;
        end else if (singleStartDebit) begin
            grown = grown - 6'h01;
        end
        credit_d = grown[3:0];
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            credit_q <= 4'h0;
            creditOne_q <= 1'b0;
            creditTwo_q <= 1'b0;
        end else begin
            credit_q <= credit_d;
            creditOne_q <= credit_d != 4'h0;
            creditTwo_q <= credit_d >= 4'h2;
        end
    end

    // play latch and attract
    assign endGame = !attract_q && endOfGame_q
        && serveState_q == credit_play_pkg::SRV_IDLE;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            playLatch_q <= 1'b0;
        end else if (|coinOk_q) begin
            playLatch_q <= 1'b1;
        end else if (endGame && credit_q == 4'h0) begin
            playLatch_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            attract_q <= 1'b1;
        end else if (seqStart) begin
            attract_q <= 1'b0;
        end else if (endGame && playLatch_q) begin
            attract_q <= 1'b1;
        end else if (!playLatch_q) begin
            attract_q <= 1'b1;
        end
    end

    // serve wait and serves counter
    always_ff @(posedge ref_clk) begin
        if (srst || attract_q) begin
            serveWait_q <= 1'b0;
            serveWaitPrev_q <= 1'b0;
        end else begin
            serveWaitPrev_q <= serveWait_q;
            if (ballOut) begin
                serveWait_q <= 1'b1;
            end else if (!serveBtnN) begin
                serveWait_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            serveState_q <= credit_play_pkg::SRV_IDLE;
            serveAdvancePulse_q <= 1'b0;
        end else begin
            serveAdvancePulse_q <= 1'b0;
            unique case (serveState_q)
                credit_play_pkg::SRV_IDLE: begin
                    if (serveWait_q && !serveWaitPrev_q) begin
                        serveState_q <= credit_play_pkg::SRV_FIRST;
                    end
                end
                credit_play_pkg::SRV_FIRST: begin
                    serveAdvancePulse_q <= 1'b1;
                    serveState_q <= twoPlayer_q ? credit_play_pkg::SRV_IDLE
                                                : credit_play_pkg::SRV_SECOND;
                end
                credit_play_pkg::SRV_SECOND: begin
                    serveAdvancePulse_q <= 1'b1;
                    serveState_q <= credit_play_pkg::SRV_IDLE;
                end
                default: serveState_q <= credit_play_pkg::SRV_IDLE;
            endcase
        end
    end

    assign ballLimit = cfg_q.servesPerGameSwitch ? `CPS_BALLS_LONG
                                                 : `CPS_BALLS_SHORT;

    always_ff @(posedge ref_clk) begin
        if (srst || seqStart) begin
            servesCnt_q <= 4'h0;
            endOfGame_q <= 1'b0;
        end else begin
            if (serveAdvancePulse_q && servesCnt_q != 4'hF) begin
                servesCnt_q <= servesCnt_q + 4'h1;
            end
            endOfGame_q <= servesCnt_q[3:1] >= ballLimit;
        end
    end

    // points counter
    // the tick runs free, so a reload never restarts it and the first point can come early
    always_ff @(posedge ref_clk) begin
        if (srst || tickCnt_q == 16'h0000) begin
            tickCnt_q <= 16'(TickCycles - 1);
        end else begin
            tickCnt_q <= tickCnt_q - 16'h0001;
        end
    end
    assign scoringClock = tickCnt_q == 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pointsCnt_q <= '0;
            pointPulse_q <= 1'b0;
        end else begin
            pointPulse_q <= 1'b0;
            if (brickHit) begin
                pointsCnt_q <= brickValue;
            end else if (scoringClock && pointsCnt_q != '0) begin
                pointsCnt_q <= pointsCnt_q - 1'b1;
                pointPulse_q <= 1'b1;
            end
        end
    end

    // per-player score, bonus and wall
    for (genvar gp = 0; gp < 2; gp++) begin : g_player
        logic upNow;
        logic reach;
        assign upNow = servesCnt_q[0] == 1'(gp);

        bcd_score_counter u_score (
            .ref_clk(ref_clk),
            .srst(srst),
            .clr(seqStart),
            .inc(pointPulse_q && upNow),
            .digits(scores[12*gp +: 12])
        );

        // only the hundreds digit is compared, finer thresholds need more
        assign reach = cfg_q.bonusThresholdSwitch != `CPS_BONUS_OFF
            && scores[12*gp+8 +: 4] >= cfg_q.bonusThresholdSwitch;

        always_ff @(posedge ref_clk) begin
            if (srst || seqStart) begin
                bonusLatch_q[gp] <= 1'b0;
                bonusPulse_q[gp] <= 1'b0;
                wallFlag_q[gp] <= 1'b0;
                wallRestore_q[gp] <= 1'b0;
            end else begin
                bonusPulse_q[gp] <= reach && !bonusLatch_q[gp]
                    && !attract_q;
                if (reach && !attract_q) begin
                    bonusLatch_q[gp] <= 1'b1;
                end
                wallRestore_q[gp] <= 1'b0;
                if (upNow && wallEmpty && (paddleHit || backWallHit)
                        && !wallFlag_q[gp] && !attract_q) begin
                    wallFlag_q[gp] <= 1'b1;
                    wallRestore_q[gp] <= 1'b1;
                end
            end
        end
    end

    // bonus tone timer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            toneCnt_q <= 32'h0000_0000;
            bonusTone_q <= 1'b0;
        end else begin
            if (|bonusPulse_q) begin
                toneCnt_q <= ToneCycles;
            end else if (toneCnt_q != 32'h0000_0000) begin
                toneCnt_q <= toneCnt_q - 32'h0000_0001;
            end
            bonusTone_q <= (|bonusPulse_q) || toneCnt_q > 32'h0000_0001;
        end
    end

    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign playLatch = playLatch_q;
    assign attract = attract_q;
    assign startLamp1 = creditOne_q;
    assign startLamp2 = creditTwo_q;
    assign serveLamp = serveWait_q;
    assign bonusTone = bonusTone_q;
    assign pointPulse = pointPulse_q;
    assign p1WallRestore = wallRestore_q[0];
    assign p2WallRestore = wallRestore_q[1];
    assign playerTwoUp = servesCnt_q[0];
    assign endOfGameLevel = endOfGame_q;
    assign ballNumber = servesCnt_q[3:1];
endmodule
`default_nettype wire

// File: tb/credit_play_chk.sv
// port-level assertions for the credit and play sequencer
`default_nettype none
module credit_play_chk #(
    parameter int unsigned ToneCycles = 20,
    parameter int unsigned CoinMinCycles = 4,
    parameter int unsigned TickCycles = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // cabinet and playfield inputs
    input wire logic slotASwitch,
    input wire logic startOneBtn,
    input wire logic startTwoBtn,
    input wire logic paddleHit,
    input wire logic backWallHit,
    input wire logic wallEmpty,
    input wire logic ballOut,
    // game state outputs
    input wire logic playLatch,
    input wire logic attract,
    input wire logic startLamp1,
    input wire logic startLamp2,
    input wire logic serveLamp,
    input wire logic bonusTone,
    input wire logic pointPulse,
    input wire logic p1WallRestore,
    input wire logic playerTwoUp,
    input wire logic endOfGameLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned toneCnt_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // counts the cycles the tone stays on, judged when it drops
    always_ff @(posedge ref_clk) begin
        toneCnt_q <= (srst || !bonusTone) ? 0 : toneCnt_q + 1;
    end
    chk_lamp_order: assert property (startLamp2 |-> startLamp1)
        else $error("two-credit lamp lit without one-credit lamp");
    chk_coin_play: assert property (
        slotASwitch [*4] |-> ##[1:4] playLatch)
        else $error("accepted coin did not set play mode");
    chk_start_one: assert property (
        attract && playLatch && startLamp1 && $rose(startOneBtn)
        |=> !attract)
        else $error("lit single start not taken");
    chk_two_needs_two: assert property (
        attract && !startLamp2 && !startOneBtn && $rose(startTwoBtn)
        |=> attract)
        else $error("double start taken without credits");
    chk_wait_in_attract: assert property (
        attract [*2] |-> !serveLamp)
        else $error("serve wait lit in attract");
    chk_ball_out_wait: assert property (
        ballOut && !attract && !endOfGameLevel |=> serveLamp)
        else $error("ball out did not raise serve wait");
    chk_point_spacing: assert property (
        pointPulse |=> !pointPulse [*3])
        else $error("point pulses faster than the scoring tick");
    chk_wall_cause: assert property (
        p1WallRestore |-> $past(wallEmpty) && !$past(playerTwoUp)
        && ($past(paddleHit) || $past(backWallHit)))
        else $error("wall restore without empty wall and hit");
    chk_tone_length: assert property (
        $fell(bonusTone) |-> toneCnt_q == ToneCycles)
        else $error("bonus tone length wrong");
endmodule
bind credit_play_sequencer credit_play_chk #(
    .ToneCycles(ToneCycles),
    .CoinMinCycles(CoinMinCycles),
    .TickCycles(TickCycles)
) i_credit_play_chk (.ref_clk, .srst, .slotASwitch, .startOneBtn,
    .startTwoBtn, .paddleHit, .backWallHit, .wallEmpty, .ballOut,
    .playLatch, .attract, .startLamp1, .startLamp2, .serveLamp,
    .bonusTone, .pointPulse, .p1WallRestore, .playerTwoUp,
    .endOfGameLevel);
`default_nettype wire

// File: tb/cabinet_panel.sv
// model of the coin mechanisms and the cabinet push buttons
`default_nettype none
module cabinet_panel (
    // clock
    input wire logic ref_clk,
    // requests from the bench
    input wire logic coinGo,
    input wire logic coinSlotB,
    input wire logic [7:0] coinLen,
    input wire logic [2:0] pressGo,
    // switch levels toward the sequencer
    output logic slotASwitch,
    output logic slotBSwitch,
    output logic startOneBtn,
    output logic startTwoBtn,
    output logic serveBtnN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] coinLeft_q = 8'h00;
    logic slotB_q = 1'b0;
    logic [2:0] btn_q = 3'h0;
    logic [1:0] btnLeft_q = 2'h0;
    always @(posedge ref_clk) begin
        if (coinGo) begin
            coinLeft_q <= coinLen;
            slotB_q <= coinSlotB;
        end else if (coinLeft_q != 8'h00) begin
            coinLeft_q <= coinLeft_q - 8'h01;
        end
    end
    // a button is held three cycles, one press at a time
    always @(posedge ref_clk) begin
        if (pressGo != 3'h0) begin
            btn_q <= pressGo;
            btnLeft_q <= 2'h3;
        end else if (btnLeft_q != 2'h0) begin
            btnLeft_q <= btnLeft_q - 2'h1;
        end
    end
    assign slotASwitch = coinLeft_q != 8'h00 && !slotB_q;
    assign slotBSwitch = coinLeft_q != 8'h00 && slotB_q;
    assign startOneBtn = btnLeft_q != 2'h0 && btn_q[0];
    assign startTwoBtn = btnLeft_q != 2'h0 && btn_q[1];
    // serve line idles high through its pull-up
    assign serveBtnN = !(btnLeft_q != 2'h0 && btn_q[2]);
endmodule
`default_nettype wire

// File: tb/credit_play_sequencer_tb.sv
// self-checking bench for the credit and play sequencer
`default_nettype none
module credit_play_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] paddr = 8'h00, coinLen = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, lastErr;
    logic slotASwitch, slotBSwitch, startOneBtn, startTwoBtn, serveBtnN;
    logic brickHit = 1'b0, paddleHit = 1'b0, backWallHit = 1'b0;
    logic wallEmpty = 1'b0, ballOut = 1'b0, coinGo = 1'b0, coinSlotB = 1'b0;
    logic [2:0] brickValue = 3'h0, pressGo = 3'h0, ballNumber;
    logic playLatch, attract, startLamp1, startLamp2, serveLamp;
    logic bonusTone, pointPulse, p1WallRestore, p2WallRestore;
    logic playerTwoUp, endOfGameLevel;
    int errors = 0, checks = 0, cycles = 0, wallSeen = 0;
    credit_play_sequencer #(.ToneCycles(20), .CoinMinCycles(4),
        .TickCycles(4)) i_credit_play_sequencer (.ref_clk, .srst, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .slotASwitch, .slotBSwitch, .startOneBtn, .startTwoBtn,
        .serveBtnN, .brickHit, .brickValue, .paddleHit, .backWallHit,
        .wallEmpty, .ballOut, .playLatch, .attract, .startLamp1,
        .startLamp2, .serveLamp, .bonusTone, .pointPulse, .p1WallRestore,
        .p2WallRestore, .playerTwoUp, .endOfGameLevel, .ballNumber);
    cabinet_panel i_cabinet_panel (.ref_clk, .coinGo, .coinSlotB,
        .coinLen, .pressGo, .slotASwitch, .slotBSwitch, .startOneBtn,
        .startTwoBtn, .serveBtnN);
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (p1WallRestore === 1'b1) wallSeen++;
        if (p2WallRestore === 1'b1) wallSeen += 16;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stat(input logic at, input logic pl, input logic [3:0] c);
        logic [31:0] d;
        apb(1'b0, 8'h04, 32'h0, d);
        check(d & 32'h3F, {26'h0, at, pl, c});
    endtask
    task automatic coin(input logic b, input logic [7:0] len);
        @(posedge ref_clk);
        coinGo <= 1'b1;
        coinSlotB <= b;
        coinLen <= len;
        @(posedge ref_clk);
        coinGo <= 1'b0;
        repeat (len + 14) @(posedge ref_clk);
    endtask
    task automatic press(input logic [2:0] which);
        @(posedge ref_clk);
        pressGo <= which;
        @(posedge ref_clk);
        pressGo <= 3'h0;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic hit(input logic [2:0] v);
        @(posedge ref_clk);
        brickHit <= 1'b1;
        brickValue <= v;
        @(posedge ref_clk);
        brickHit <= 1'b0;
        repeat (4 * v + 12) @(posedge ref_clk);
    endtask
    task automatic serve(input logic lit);
        @(posedge ref_clk);
        ballOut <= 1'b1;
        @(posedge ref_clk);
        ballOut <= 1'b0;
        @(negedge ref_clk);
        check(32'(serveLamp), 32'(lit));
        press(3'h4);
    endtask
    function automatic logic [11:0] bcd(input int v);
        return {4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    initial begin
        logic [31:0] d;
        logic [5:0] cfg;
        int sum, v;
        void'($urandom(32'hBE8D));
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        stat(1'b1, 1'b0, 4'h0);
        apb(1'b0, 8'h0C, 32'h0, d);
        check({31'h0, lastErr}, 32'h1);
        cfg = 6'($urandom);
        apb(1'b1, 8'h00, {26'h0, cfg}, d);
        apb(1'b0, 8'h00, 32'h0, d);
        check(d, {26'h0, cfg});
        apb(1'b1, 8'h00, 32'h0, d);
        coin(1'b0, 8'h03);
        stat(1'b1, 1'b0, 4'h0);
        coin(1'b0, 8'h06);
        stat(1'b1, 1'b1, 4'h1);
        press(3'h2);
        stat(1'b1, 1'b1, 4'h1);
        // two credits per coin, bonus from the first hundred
        apb(1'b1, 8'h00, 32'h5, d);
        coin(1'b1, 8'h06);
        stat(1'b1, 1'b1, 4'h3);
        check(32'({startLamp2, startLamp1}), 32'h3);
        press(3'h2);
        stat(1'b0, 1'b1, 4'h1);
        press(3'h1);
        stat(1'b0, 1'b1, 4'h1);
        sum = 0;
        while (sum < 100) begin
            v = $urandom_range(7, 1);
            hit(3'(v));
            sum += v;
        end
        apb(1'b0, 8'h08, 32'h0, d);
        check(d, {20'h0, bcd(sum)});
        stat(1'b0, 1'b1, 4'h2);
        {wallEmpty, paddleHit} <= 2'h3;
        @(posedge ref_clk);
        {paddleHit, backWallHit} <= 2'h1;
        @(posedge ref_clk);
        {wallEmpty, backWallHit} <= 2'h0;
        repeat (3) @(posedge ref_clk);
        check(32'(wallSeen), 32'h1);
        serve(1'b1);
        check(32'({playerTwoUp, ballNumber}), 32'h8);
        hit(3'h5);
        apb(1'b0, 8'h08, 32'h0, d);
        check(d, {4'h0, bcd(5), 4'h0, bcd(sum)});
        {wallEmpty, backWallHit} <= 2'h3;
        @(posedge ref_clk);
        {wallEmpty, backWallHit} <= 2'h0;
        repeat (3) @(posedge ref_clk);
        check(32'(wallSeen), 32'h11);
        repeat (4) serve(1'b1);
        check(32'(endOfGameLevel), 32'h0);
        serve(1'b1);
        check(32'({endOfGameLevel, ballNumber}), 32'hB);
        stat(1'b1, 1'b1, 4'h2);
        // five serves, bonus off
        apb(1'b1, 8'h00, 32'h3, d);
        press(3'h2);
        stat(1'b0, 1'b1, 4'h0);
        apb(1'b0, 8'h08, 32'h0, d);
        check(d, 32'h0);
        repeat (9) serve(1'b1);
        check(32'(endOfGameLevel), 32'h0);
        serve(1'b1);
        stat(1'b1, 1'b0, 4'h0);
        serve(1'b0);
        press(3'h2);
        stat(1'b1, 1'b0, 4'h0);
        repeat ($urandom_range(10, 8)) coin(1'b1, 8'($urandom_range(12, 5)));
        stat(1'b1, 1'b1, 4'hF);
        press(3'h1);
        stat(1'b0, 1'b1, 4'hE);
        serve(1'b1);
        check(32'({playerTwoUp, ballNumber}), 32'h1);
        conclude();
    end
endmodule
`default_nettype wire
